// ===== core/cjtf_core.sv
/*
  Cluster jet and narrow-jet finder core: clustering, classing, ranking,
  top-four sorts, strip sums, link error zeroing and error counters.
  Assumes region data, error flags and resync arrive synchronous to clk,
  one word per crossing, and neighbour columns come already cleaned.
*/
// Design decisions made here: the placing of the registers and the plain strobed port.
// What this block does
// - Region input: 10-bit energy plus veto
// - Share own regions with neighbour cards
// - Sum 3x3 regions around every own region
// - Centre beats right, bottom; ties left, top
// - 36 sums per crossing, central and forward
// - Central sum unvetoed is narrow-jet candidate
// - Compress to 6-bit rank, 5-bit position
// - Sort each category, keep top four
// - Forward top four per category out
// - Four strip sums: two bins, two halves
// - Strip sum is 10 bits plus overflow
// - Results leave as 11-bit words
// - Sync error zeroes that link's data
// - Sync error interrupts and counts per link
// - Resync signal restores link automatically
// - Data error zeroes that link's data
// - Host enables and reads error counters
// - Four logic cycles make one crossing
// - Clustering done within nine crossings
`timescale 1ns/1ps
module cjtf_core
  import cjtf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Region links
  input  wire cjtf_grid_t        region_in,
  input  wire logic [N_LINK-1:0] sync_err,
  input  wire logic [N_LINK-1:0] data_err,
  input  wire logic              resync,
  // Neighbour sharing
  output cjtf_region_t [N_OWN-1:0] share_out,
  // Results
  output cjtf_out_t              result,
  output logic                   result_valid,
  output logic                   xing_start,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   irq
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic cjtf_region_t reg_at(input cjtf_grid_t g, input int r, input int c);
    cjtf_region_t z;
    z = '0;
    if (r >= 0 && r < N_ROW && c >= 0 && c < N_COL) begin
      z = g[r * N_COL + c];
    end
    return z;
  endfunction : reg_at

  function automatic logic [RANK_W-1:0] rank_of(input logic [SUM_W-1:0] s);
    logic [SUM_W-1:0] sh;
    sh = s >> RANK_SHIFT;
    return (sh > SUM_W'(RANK_MAX)) ? RANK_MAX : sh[RANK_W-1:0];
  endfunction : rank_of

  function automatic cjtf_cand4_t top4(input cjtf_cand28_t c);
    cjtf_cand4_t t;
    cjtf_cand_t  x;
    cjtf_cand_t  y;
    t = '0;
    for (int i = 0; i < N_CEN; i++) begin
      x = c[i];
      for (int k = 0; k < N_TOP; k++) begin
        if (x.rank > t[k].rank) begin
          y    = t[k];
          t[k] = x;
          x    = y;
        end
      end
    end
    return t;
  endfunction : top4

  // ****************************************
  // State
  // ****************************************
  cjtf_state_t q;
  cjtf_state_t d;
  logic        xing;
  logic        clr_cnt;

  assign xing    = (q.phase == PHASE_LAST);
  assign clr_cnt = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_CLR_BIT];

  always_comb begin
    cjtf_region_t      ctr;
    cjtf_region_t      nb;
    cjtf_cand28_t      cen_c;
    cjtf_cand28_t      tau_c;
    cjtf_cand28_t      fwd_c;
    logic [SUM_W-1:0]  s;
    logic              v;
    logic              bad;
    int                k;
    int                lk;
    int                fp;
    ctr   = '0;
    nb    = '0;
    cen_c = '0;
    tau_c = '0;
    fwd_c = '0;
    s     = '0;
    v     = 1'b0;
    bad   = 1'b0;
    k     = 0;
    lk    = 0;
    fp    = 0;
    d     = q;
    d.phase     = q.phase + 2'h1;
    d.out_valid = 1'b0;

    // Control register
    if (reg_wr && reg_addr == REG_CTRL) begin
      d.ctrl_mon = reg_wdata[CTRL_MON_BIT];
      d.ctrl_irq = reg_wdata[CTRL_IRQ_BIT];
    end

    for (int i = 0; i < N_LINK; i++) begin
      if (resync) begin
        d.link_bad[i] = 1'b0;
      end
      if (xing && sync_err[i]) begin
        d.link_bad[i] = 1'b1;
      end
      if (clr_cnt) begin
        d.sync_cnt[i] = '0;
        d.data_cnt[i] = '0;
      end
      if (xing && q.ctrl_mon && sync_err[i] && d.sync_cnt[i] != CNT_MAX) begin
        d.sync_cnt[i] = d.sync_cnt[i] + CNT_W'(1);
      end
      if (xing && q.ctrl_mon && data_err[i] && d.data_cnt[i] != CNT_MAX) begin
        d.data_cnt[i] = d.data_cnt[i] + CNT_W'(1);
      end
    end

    d.irq = q.ctrl_irq && (|q.link_bad);

    if (xing) begin
      // Stage 1: capture and clean inputs
      // Energy and veto captured
      d.v1 = 1'b1;
      for (int r = 0; r < N_ROW; r++) begin
        for (int c = 0; c < N_COL; c++) begin
          d.grid[r * N_COL + c] = region_in[r * N_COL + c];
          if (c == 1 || c == 2) begin
            lk  = (r * 2 + c - 1) / REG_PER_LINK;
            bad = sync_err[lk] | q.link_bad[lk] | data_err[lk];
            if (bad) begin
              d.grid[r * N_COL + c] = '0;
            end
          end
        end
      end

      // Stage 2: clusters and strips
      d.v2 = q.v1;
      for (int r = 0; r < N_ROW; r++) begin
        for (int c = 1; c <= 2; c++) begin
          k   = r * 2 + c - 1;
          s   = '0;
          v   = 1'b0;
          ctr = reg_at(q.grid, r, c);
          for (int dr = -1; dr <= 1; dr++) begin
            for (int dc = -1; dc <= 1; dc++) begin
              nb = reg_at(q.grid, r + dr, c + dc);
              s  = s + SUM_W'(nb.et);
              v  = v | nb.veto;
            end
          end
          d.cl_sum[k]  = s;
          d.cl_veto[k] = v;
          d.cl_ok[k] = (ctr.et >  reg_at(q.grid, r, c + 1).et) &&
                       (ctr.et >  reg_at(q.grid, r + 1, c).et) &&
                       (ctr.et >= reg_at(q.grid, r, c - 1).et) &&
                       (ctr.et >= reg_at(q.grid, r - 1, c).et);
        end
      end
      // Strip sums per bin and half
      for (int st = 0; st < N_STRIP; st++) begin
        s = '0;
        for (int r = 0; r < HALF_ROWS; r++) begin
          s = s + SUM_W'(reg_at(q.grid, (st / 2) * HALF_ROWS + r, 1 + st % 2).et);
        end
        d.st_sum[st] = s;
      end

      // Stage 3: class, rank, sort
      // Central and forward groups
      for (int r = 0; r < N_ROW; r++) begin
        for (int c = 0; c < 2; c++) begin
          k = r * 2 + c;
          if (r >= CEN_ROW_LO && r <= CEN_ROW_HI) begin
            if (q.cl_ok[k] && !q.cl_veto[k]) begin
              tau_c[k - 2 * CEN_ROW_LO].rank = rank_of(q.cl_sum[k]);
            end
            if (q.cl_ok[k] && q.cl_veto[k]) begin
              cen_c[k - 2 * CEN_ROW_LO].rank = rank_of(q.cl_sum[k]);
            end
            tau_c[k - 2 * CEN_ROW_LO].pos = POS_W'(k - 2 * CEN_ROW_LO);
            cen_c[k - 2 * CEN_ROW_LO].pos = POS_W'(k - 2 * CEN_ROW_LO);
          end else begin
            fp = (r < CEN_ROW_LO) ? k : k - 2 * (FWD_ROW_HI - CEN_ROW_LO);
            if (q.cl_ok[k]) begin
              fwd_c[fp].rank = rank_of(q.cl_sum[k]);
            end
            fwd_c[fp].pos = POS_W'(fp);
          end
        end
      end
      // Each result is an 11-bit word
      d.out.cen = top4(cen_c);
      d.out.tau = top4(tau_c);
      d.out.fwd = top4(fwd_c);
      for (int st = 0; st < N_STRIP; st++) begin
        d.out.strip[st].ovf = q.st_sum[st] > STRIP_MAX;
        d.out.strip[st].et  = (q.st_sum[st] > STRIP_MAX) ? ET_SAT :
                              q.st_sum[st][ET_W-1:0];
      end
      d.out_valid = q.v2;
    end

    // Host read of counters and status
    if (reg_rd) begin
      d.rdata = '0;
      if (reg_addr == REG_CTRL) begin
        d.rdata[CTRL_MON_BIT] = q.ctrl_mon;
        d.rdata[CTRL_IRQ_BIT] = q.ctrl_irq;
      end
      if (reg_addr == REG_STATUS) begin
        d.rdata = 32'(q.link_bad);
      end
      for (int i = 0; i < N_LINK; i++) begin
        if (reg_addr == REG_SYNC_BASE + 8'(4 * i)) begin
          d.rdata = 32'(q.sync_cnt[i]);
        end
        if (reg_addr == REG_DATA_BASE + 8'(4 * i)) begin
          d.rdata = 32'(q.data_cnt[i]);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q          <= '0;
      q.ctrl_mon <= CTRL_MON_RESET;
      q.ctrl_irq <= CTRL_IRQ_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Cleaned own regions to neighbours
  generate
    for (genvar g = 0; g < N_OWN; g++) begin : g_share
      assign share_out[g] = q.grid[(g / 2) * N_COL + 1 + g % 2];
    end
  endgenerate
  assign result       = q.out;
  assign result_valid = q.out_valid;
  assign xing_start   = xing;
  assign reg_rdata    = q.rdata;
  assign irq          = q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_xing_period;
    xing |=> !xing [*3] ##1 xing;
  endproperty
  a_xing_period: assert property (p_xing_period) else $error("crossing period wrong");

  property p_latency;
    (xing && q.v1) |-> ##5 result_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("result late");

  property p_sync_zero;
    (xing && sync_err[0]) |=> (q.grid[1].et == '0) ##4
      (!$past(q.link_bad[0]) || q.grid[1].et == '0);
  endproperty
  a_sync_zero: assert property (p_sync_zero) else $error("bad link not zeroed");

  property p_data_zero;
    (xing && data_err[1]) |=> (q.grid[5 * N_COL + 1] == '0);
  endproperty
  a_data_zero: assert property (p_data_zero) else $error("data error not zeroed");

  property p_no_veto;
    (xing && sync_err[2]) |=> !q.grid[6 * N_COL + 2].veto;
  endproperty
  a_no_veto: assert property (p_no_veto) else $error("zeroed region vetoes");

  property p_resync;
    (resync && !(xing && sync_err[0])) |=> !q.link_bad[0];
  endproperty
  a_resync: assert property (p_resync) else $error("resync not restored");

  property p_sync_cnt;
    (xing && sync_err[0] && q.ctrl_mon && !clr_cnt && q.sync_cnt[0] != CNT_MAX)
      |=> q.sync_cnt[0] == $past(q.sync_cnt[0]) + CNT_W'(1);
  endproperty
  a_sync_cnt: assert property (p_sync_cnt) else $error("sync count missed");

  property p_status_read;
    (reg_rd && reg_addr == REG_STATUS) |=> reg_rdata == 32'($past(q.link_bad));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_sorted;
    result_valid |-> (result.tau[0].rank >= result.tau[1].rank) &&
                     (result.tau[1].rank >= result.tau[2].rank) &&
                     (result.cen[2].rank >= result.cen[3].rank);
  endproperty
  a_sorted: assert property (p_sorted) else $error("top four not sorted");

  property p_strip_ovf;
    result_valid && result.strip[2].ovf |-> result.strip[2].et == ET_SAT;
  endproperty
  a_strip_ovf: assert property (p_strip_ovf) else $error("strip overflow value");

endmodule : cjtf_core

// ===== core/cjtf_pkg.sv
/*
  Shared constants and types of the cluster jet and narrow-jet finder.
  Assumes one 160 MHz logic clock with four cycles to a crossing.
*/
package cjtf_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int N_ROW        = 18;
  localparam int N_COL        = 4;
  localparam int N_REG        = N_ROW * N_COL;
  localparam int N_OWN        = 36;
  localparam int N_LINK       = 6;
  localparam int REG_PER_LINK = 6;
  localparam int N_CEN        = 28;
  localparam int N_TOP        = 4;
  localparam int N_STRIP      = 4;
  localparam int CEN_ROW_LO   = 2;
  localparam int CEN_ROW_HI   = 15;
  localparam int FWD_ROW_HI   = 16;
  localparam int HALF_ROWS    = 9;
  // ****************************************
  // Timing
  // ****************************************
  localparam int LOGIC_CYCLE_PS  = 6250;
  localparam int XING_PS         = 25000;
  localparam int CYCLES_PER_XING = XING_PS / LOGIC_CYCLE_PS;
  localparam logic [1:0] PHASE_LAST = 2'(CYCLES_PER_XING - 1);
  localparam int MAX_LAT_XING    = 9;
  // ****************************************
  // Widths and scaling
  // ****************************************
  localparam int ET_W   = 10;
  localparam int SUM_W  = 14;
  localparam int RANK_W = 6;
  localparam int POS_W  = 5;
  localparam int CNT_W  = 16;
  localparam int RANK_SHIFT = 2;
  localparam logic [RANK_W-1:0] RANK_MAX   = 6'h3F;
  localparam logic [SUM_W-1:0]  STRIP_MAX  = 14'h03FF;
  localparam logic [ET_W-1:0]   ET_SAT     = 10'h3FF;
  localparam logic [CNT_W-1:0]  CNT_MAX    = 16'hFFFF;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_SYNC_BASE = 8'h10;
  localparam logic [7:0] REG_DATA_BASE = 8'h30;
  localparam int CTRL_MON_BIT = 0;
  localparam int CTRL_IRQ_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam logic CTRL_MON_RESET = 1'b0;
  localparam logic CTRL_IRQ_RESET = 1'b0;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic            veto;
    logic [ET_W-1:0] et;
  } cjtf_region_t;
  typedef struct packed {
    logic [RANK_W-1:0] rank;
    logic [POS_W-1:0]  pos;
  } cjtf_cand_t;
  typedef struct packed {
    logic            ovf;
    logic [ET_W-1:0] et;
  } cjtf_strip_t;
  typedef cjtf_cand_t [N_CEN-1:0] cjtf_cand28_t;
  typedef cjtf_cand_t [N_TOP-1:0] cjtf_cand4_t;
  typedef cjtf_region_t [N_REG-1:0] cjtf_grid_t;
  typedef struct packed {
    cjtf_cand4_t                    cen;
    cjtf_cand4_t                    fwd;
    cjtf_cand4_t                    tau;
    cjtf_strip_t [N_STRIP-1:0]      strip;
  } cjtf_out_t;
  typedef struct packed {
    logic [1:0]                     phase;
    logic                           ctrl_mon;
    logic                           ctrl_irq;
    logic [N_LINK-1:0]              link_bad;
    logic [N_LINK-1:0][CNT_W-1:0]   sync_cnt;
    logic [N_LINK-1:0][CNT_W-1:0]   data_cnt;
    cjtf_grid_t                     grid;
    logic                           v1;
    logic                           v2;
    logic [N_OWN-1:0][SUM_W-1:0]    cl_sum;
    logic [N_OWN-1:0]               cl_ok;
    logic [N_OWN-1:0]               cl_veto;
    logic [N_STRIP-1:0][SUM_W-1:0]  st_sum;
    cjtf_out_t                      out;
    logic                           out_valid;
    logic [31:0]                    rdata;
    logic                           irq;
  } cjtf_state_t;
endpackage : cjtf_pkg

// ===== test/cjtf_region_src.sv
/*
  Region source model standing in for the upstream crates.
  Assumes the bench sets grid and error flags; off the capture cycle
  every line shows the inverse, so a late or early sample shows up.
*/
`timescale 1ns/1ps
module cjtf_region_src
  import cjtf_pkg::*;
(
  // Capture timing
  input  wire logic              xing_start,
  // Bench side
  input  wire cjtf_grid_t        grid_in,
  input  wire logic [N_LINK-1:0] se_in,
  input  wire logic [N_LINK-1:0] de_in,
  // Card side
  output cjtf_grid_t             region_out,
  output logic [N_LINK-1:0]      sync_err,
  output logic [N_LINK-1:0]      data_err
);
  assign region_out = xing_start ? grid_in : ~grid_in;
  assign sync_err   = xing_start ? se_in : ~se_in;
  assign data_err   = xing_start ? de_in : ~de_in;
endmodule : cjtf_region_src

// ===== test/cjtf_core_test.sv
/*
  Self-checking bench for the cluster finder core.
  Assumes the region source model in front and the plain register port.
*/
`timescale 1ns/1ps
module cjtf_core_test
  import cjtf_pkg::*;
  ;
  logic                     clk, rst, resync, reg_wr, reg_rd;
  logic [7:0]               reg_addr;
  logic [31:0]              reg_wdata, reg_rdata;
  logic [N_LINK-1:0]        se, de, sync_err, data_err;
  cjtf_grid_t               g, ng, region_in;
  cjtf_region_t [N_OWN-1:0] share_out;
  cjtf_out_t                result, e, ok;
  logic                     result_valid, xing_start, irq;
  int                       err_total, compares;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  cjtf_region_src cjtf_region_src_i (.xing_start(xing_start), .grid_in(g), .se_in(se),
    .de_in(de), .region_out(region_in), .sync_err(sync_err), .data_err(data_err));
  cjtf_core cjtf_core_i (.clk(clk), .rst(rst), .region_in(region_in), .sync_err(sync_err),
    .data_err(data_err), .resync(resync), .share_out(share_out), .result(result),
    .result_valid(result_valid), .xing_start(xing_start), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));

  // ****************************************
  // Tasks
  // ****************************************
  task end_sim;
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [31:0] x, input logic [31:0] y);
    compares++;
    if (y !== x) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, x, y);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", x, reg_rdata);
  endtask : rd

  task put(input int r, input int c, input logic [9:0] et, input logic v);
    ng[r*4+c].et   = et;
    ng[r*4+c].veto = v;
  endtask : put

  task clean;
    ng = '0;
    e  = '0;
  endtask : clean

  task run_xing(input logic [5:0] s, input logic [5:0] d);
    int n;
    n = 0;
    @(posedge clk);
    g  <= ng;
    se <= s;
    de <= d;
    @(negedge clk);
    while (xing_start !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (n == 8) begin
      err_total++;
      end_sim;
    end
    @(posedge clk);
    se <= '0;
    de <= '0;
    repeat (3) @(posedge clk);
    #1 chk("xing_start", 1, xing_start);
    repeat (5) @(posedge clk);
    #1 chk("result_valid", 1, result_valid);
    compares++;
    if (result !== e) begin
      err_total++;
      $display("wrong value result expected %h seen %h", e, result);
    end
  endtask : run_xing

  task pulse_resync;
    @(posedge clk);
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
  endtask : pulse_resync

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    resync = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    se = '0;
    de = '0;
    g = '0;
    err_total = 0;
    compares = 0;
    clean;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 chk("irq", 0, irq);
    rd(REG_CTRL, 0);
    rd(REG_STATUS, 0);
    rd(8'h08, 0);
    // Lone cluster, then a veto beside it
    put(5, 1, 10'h028, 1'b0);
    e.tau[0] = '{6'h0A, 5'h06};
    e.strip[0] = '{1'b0, 10'h028};
    run_xing('0, '0);
    chk("share_out", {1'b0, 10'h028}, share_out[10]);
    put(5, 2, 10'h000, 1'b1);
    e.cen[0] = e.tau[0];
    e.tau[0] = '0;
    run_xing('0, '0);
    chk("share_out", {1'b1, 10'h000}, share_out[11]);
    // Equal neighbours: only the right one qualifies
    clean;
    put(5, 1, 10'h01C, 1'b0);
    put(5, 2, 10'h01C, 1'b0);
    e.tau[0] = '{6'h0E, 5'h07};
    e.strip[0] = '{1'b0, 10'h01C};
    e.strip[1] = '{1'b0, 10'h01C};
    run_xing('0, '0);
    // Forward rows at both ends
    clean;
    put(0, 2, 10'h028, 1'b0);
    put(17, 1, 10'h008, 1'b0);
    e.fwd[0] = '{6'h0A, 5'h01};
    e.fwd[1] = '{6'h02, 5'h06};
    e.strip[1] = '{1'b0, 10'h028};
    e.strip[2] = '{1'b0, 10'h008};
    run_xing('0, '0);
    // Five candidates, four kept in rank order
    clean;
    for (int i = 0; i < 5; i++) put(2 + 2 * i, 1, 10'(40 * (i + 1)), 1'b0);
    for (int i = 0; i < 4; i++) e.tau[i] = '{6'(50 - 10 * i), 5'(16 - 4 * i)};
    e.strip[0] = '{1'b0, 10'h190};
    e.strip[2] = '{1'b0, 10'h0C8};
    run_xing('0, '0);
    // Saturated ranks and strip overflow
    clean;
    for (int i = 0; i < 3; i++) put(10 + 2 * i, 1, 10'h3FF, 1'b0);
    for (int i = 0; i < 3; i++) e.tau[i] = '{6'h3F, 5'(16 + 4 * i)};
    e.strip[2] = '{1'b1, 10'h3FF};
    run_xing('0, '0);
    // Link errors, counters and resync
    clean;
    put(5, 1, 10'h028, 1'b0);
    wr(REG_CTRL, 32'h0000_0003);
    run_xing(6'h03, '0);
    chk("share_out", 0, share_out[10]);
    rd(REG_STATUS, 32'h0000_0003);
    rd(REG_SYNC_BASE, 1);
    rd(REG_SYNC_BASE + 8'h04, 1);
    chk("irq", 1, irq);
    run_xing('0, '0);
    pulse_resync;
    e.tau[0] = '{6'h0A, 5'h06};
    e.strip[0] = '{1'b0, 10'h028};
    ok = e;
    run_xing('0, '0);
    rd(REG_STATUS, 0);
    chk("irq", 0, irq);
    e = '0;
    run_xing('0, 6'h02);
    e = ok;
    run_xing('0, '0);
    rd(REG_DATA_BASE + 8'h04, 1);
    wr(REG_CTRL, 32'h0000_0007);
    rd(REG_SYNC_BASE + 8'h04, 0);
    rd(REG_DATA_BASE + 8'h04, 0);
    rd(REG_CTRL, 32'h0000_0003);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(REG_CTRL, 32'h0000_0003);
    wr(REG_CTRL, 0);
    // Bad links: energy and veto both dropped
    put(0, 1, 10'h3FF, 1'b1);
    put(6, 2, 10'h000, 1'b1);
    run_xing(6'h05, '0);
    chk("share_out", 0, share_out[0]);
    chk("share_out", 0, share_out[13]);
    rd(REG_SYNC_BASE, 0);
    rd(REG_STATUS, 32'h0000_0005);
    chk("irq", 0, irq);
    pulse_resync;
    rd(REG_STATUS, 0);
    end_sim;
  end
endmodule : cjtf_core_test
